// >>> verification/sam_core_model.sv
// processor core model issuing register accesses and mode events
`timescale 1ns/1ps
`default_nettype none
module sam_core_model
	import sam_pkg::*;
(
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] ev,
	output logic [23:0] call_target
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ev = 8'h00;
		// only the fixed user entry is ever called
		call_target = SAM_USER_ENTRY;
	end

	// one-cycle access, strobes never overlap
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// released bus shows the inverse, never a stale value
		reg_wdata <= ~d;
	endtask

	// one-cycle event pulse, bit order of ev as wired in the bench
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verification/test_sfr_access_mode_control.sv
// self-checking bench for register access and mode control
`timescale 1ns/1ps
`default_nettype none
module test_sfr_access_mode_control;
	import sam_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ev;
	logic reg_wr, reg_rd, exc_req, push_ret, force_reset, rd_d = 1'b0;
	logic [15:0] grant_user = 16'h0000, grant_fw = 16'h0000, key_wr_stb;
	logic [23:0] call_target;
	logic [2:0] cur_mode, exc_mode;
	logic [1:0] irq_mode;
	logic [31:0] lfsr = 32'h0001058F;
	logic [8:0] e;
	logic [2:0] exc_q[$];
	logic [8:0] rd_q[$];
	int err_total = 0, n_tests = 0, cyc = 0;

	always #12.5 clk = ~clk;

	sam_core_model sam_core_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .ev(ev), .call_target(call_target));

	sam_ctrl sam_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.grant_user(grant_user), .grant_fw(grant_fw), .sys_vec_call(ev[0]),
		.fw_vec_call(ev[1]), .call_exec(ev[2]), .call_target(call_target),
		.exc_event(ev[3]), .irq_event(ev[4]), .ret_exec(ev[5]), .boot_done(ev[6]),
		.enter_test(ev[7]), .cur_mode(cur_mode), .exc_req(exc_req), .exc_mode(exc_mode),
		.push_ret(push_ret), .force_reset(force_reset), .irq_mode(irq_mode),
		.key_wr_stb(key_wr_stb));

	function automatic logic [31:0] sam_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// read; xm 4'hF means no exception, e[8] asks for a data check
	task automatic rd(input logic [7:0] a, input logic [3:0] xm, input logic [8:0] d);
		if (xm != 4'hF) exc_q.push_back(xm[2:0]);
		rd_q.push_back(d);
		sam_core_model_inst.acc(1'b0, a, 8'h00);
	endtask

	task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [2:0] m);
		sam_core_model_inst.acc(1'b1, a, d);
		#1;
		cmp(cur_mode, m);
	endtask

	task automatic ev_chk(input int i, input logic [2:0] m, input logic pr);
		sam_core_model_inst.pulse(i);
		#1;
		cmp(cur_mode, m);
		cmp(push_ret, pr);
	endtask

	// ------------------------------
	// monitor: results against the oldest note
	// ------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			end_of_test();
		end
		if (rd_d && rd_q.size() > 0) begin
			e = rd_q.pop_front();
			if (e[8]) cmp(reg_rdata, e[7:0]);
		end
		rd_d <= reg_rd;
		if (exc_req === 1'b1) begin
			if (exc_q.size() == 0) cmp(exc_req, 1'b0);
			else cmp(exc_mode, exc_q.pop_front());
		end
	end

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		cmp(cur_mode, SAM_BOOT);
		ev_chk(6, SAM_FW, 1'b0);
		cmp(force_reset, 1'b0);
		wr_chk(SAM_MODE_CTRL, 8'h00, SAM_FW);
		wr_chk(SAM_MODE_CTRL, 8'hFF, SAM_FW);
		ev_chk(4, SAM_USER, 1'b1);
		ev_chk(0, SAM_SYS, 1'b1);
		rd(SAM_MGMT_LO, 4'hF, 9'h000);
		rd(SAM_GROUP_BASE, 4'hF, 9'h000);
		wr_chk(SAM_IRQ_CFG, 8'h01, SAM_SYS);
		cmp(irq_mode, 2'h1);
		wr_chk(SAM_IRQ_CFG, 8'h00, SAM_SYS);
		cmp(irq_mode, 2'h0);
		wr_chk(SAM_KEY_LO + 8'h03, lfsr[7:0], SAM_SYS);
		cmp(key_wr_stb, 16'h0008);
		exc_q.push_back(SAM_SYS);
		ev_chk(0, SAM_SYS, 1'b1);
		ev_chk(5, SAM_SYS, 1'b0);
		ev_chk(5, SAM_USER, 1'b0);
		rd(SAM_RNG_OUT, {1'b0, SAM_USER}, 9'h100);
		rd(SAM_KEY_LO, {1'b0, SAM_USER}, 9'h100);
		rd(8'h00, {1'b0, SAM_USER}, 9'h100);
		// random grants against random groups, user side
		repeat (6) begin
			lfsr = sam_lfsr(lfsr);
			grant_user <= lfsr[31:16];
			grant_fw <= lfsr[15:0];
			@(posedge clk);
			if (grant_user[lfsr[3:0]]) rd(SAM_GROUP_BASE + {2'h0, lfsr[3:0], 2'h0}, 4'hF, 9'h000);
			else rd(SAM_GROUP_BASE + {2'h0, lfsr[3:0], 2'h0}, {1'b0, SAM_USER}, 9'h100);
		end
		exc_q.push_back(SAM_USER);
		ev_chk(5, SAM_USER, 1'b1);
		ev_chk(0, SAM_SYS, 1'b1);
		ev_chk(2, SAM_USER, 1'b0);
		ev_chk(3, SAM_USER, 1'b1);
		cmp(force_reset, 1'b1);
		sam_core_model_inst.pulse(3);
		#1;
		cmp(force_reset, 1'b1);
		repeat (3) @(posedge clk);
		cmp(exc_q.size(), 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire

// >>> verilog/sam_ctrl.sv
// register access control and processor mode sequencing
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sam_ctrl
	import sam_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [SAM_GROUPS-1:0] grant_user,
	input wire logic [SAM_GROUPS-1:0] grant_fw,
	input wire logic sys_vec_call,
	input wire logic fw_vec_call,
	input wire logic call_exec,
	input wire logic [23:0] call_target,
	input wire logic exc_event,
	input wire logic irq_event,
	input wire logic ret_exec,
	input wire logic boot_done,
	input wire logic enter_test,
	output logic [2:0] cur_mode,
	output logic exc_req,
	output logic [2:0] exc_mode,
	output logic push_ret,
	output logic force_reset,
	output logic [1:0] irq_mode,
	output logic [SAM_GROUPS-1:0] key_wr_stb
);
	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	function automatic logic is_super(input sam_mode_t m);
		is_super = (m == SAM_BOOT) || (m == SAM_TEST) || (m == SAM_FW);
	endfunction

	function automatic logic [1:0] bank_of(input sam_mode_t m);
		if (m == SAM_USER) begin
			bank_of = 2'h0;
		end else if (m == SAM_SYS) begin
			bank_of = 2'h1;
		end else begin
			bank_of = 2'h2;
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	sam_mode_t mode_reg, mode_next;
	sam_mode_t stack_reg [SAM_DEPTH];
	logic [1:0] sp_reg;
	logic [2:0] exc_busy_reg;
	logic irq_active_reg;
	logic [1:0] irq_cfg_reg;
	logic [7:0] bank_reg [3][4];
	logic [7:0] rdata_reg;
	logic exc_reg;
	logic [2:0] exc_mode_reg;
	logic push_reg;
	logic rst_reg;
	logic [SAM_GROUPS-1:0] key_stb_reg;

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	wire logic acc = reg_wr | reg_rd;
	wire logic in_group = (reg_addr >= SAM_GROUP_BASE) && (reg_addr <= SAM_GROUP_LAST);
	wire logic [3:0] grp = 4'((reg_addr - SAM_GROUP_BASE) >> SAM_GROUP_SHIFT);
	wire logic in_key = (reg_addr >= SAM_KEY_LO) && (reg_addr <= SAM_KEY_HI);
	wire logic in_rng = reg_addr == SAM_RNG_OUT;
	wire logic in_bank = (reg_addr >= SAM_BANK_LO) && (reg_addr <= SAM_BANK_HI);
	wire logic in_mc = reg_addr == SAM_MODE_CTRL;
	wire logic in_icfg = reg_addr == SAM_IRQ_CFG;
	wire logic in_mgmt = (reg_addr >= SAM_MGMT_LO) && (reg_addr <= SAM_MGMT_HI);
	wire logic mapped = in_group | in_key | in_rng | in_bank | in_mc | in_icfg | in_mgmt;
	wire logic m_sys = mode_reg == SAM_SYS;
	wire logic m_user = mode_reg == SAM_USER;
	wire logic m_sup = is_super(mode_reg);
	// system sees all groups; user and firmware need a grant
	wire logic grp_ok = m_sys || (mode_reg == SAM_TEST) || (mode_reg == SAM_BOOT) ||
		(m_user && grant_user[grp]) || ((mode_reg == SAM_FW) && grant_fw[grp]);
	// fixed rights, not configurable by any code
	wire logic key_ok = reg_wr && (m_sys || m_sup);
	wire logic rng_ok = reg_rd && (m_sys || m_sup);
	wire logic mgmt_ok = m_sys || m_sup;
	wire logic icfg_ok = reg_rd || m_sys;
	wire logic allowed = (in_group && grp_ok) || (in_key && key_ok) || (in_rng && rng_ok) ||
		in_bank || in_mc || (in_icfg && icfg_ok) || (in_mgmt && mgmt_ok);
	wire logic acc_viol = acc && (!mapped || !allowed);
	wire logic [1:0] bk = bank_of(mode_reg);
	wire logic [1:0] bidx = reg_addr[1:0];

	// ------------------------------------------------------------
	// mode transitions
	// ------------------------------------------------------------
	wire logic sysv_bad = sys_vec_call && !m_user;
	wire logic user_call = call_exec && m_sys && (call_target == SAM_USER_ENTRY);
	wire logic ret_bad = ret_exec && m_user && !(irq_cfg_reg == 2'h0 && irq_active_reg);
	wire logic ret_ok = ret_exec && !ret_bad && (sp_reg != 2'h0);
	// clear-only: system drops to user, never raised
	wire logic mc_wr = reg_wr && in_mc && allowed && !acc_viol;
	wire logic mc_drop = mc_wr && m_sys && !reg_wdata[SAM_MC_SYS];
	wire logic viol = acc_viol | sysv_bad | ret_bad;
	wire logic exc_any = exc_event | viol;
	wire logic nested = exc_any && exc_busy_reg[bank_of(mode_reg)];
	wire logic irq_go = irq_event && !exc_any;
	wire logic vec_go = (sys_vec_call && m_user) || fw_vec_call;
	wire logic push = exc_any | irq_go | vec_go;
	wire sam_mode_t irq_tgt = (irq_cfg_reg == 2'h0) ? SAM_USER :
		(irq_cfg_reg == 2'h1) ? SAM_SYS : SAM_FW;

	always_comb begin
		mode_next = mode_reg;
		if (exc_any) begin
			mode_next = mode_reg; // handler stays in the faulting mode, flagged
		end else if (vec_go) begin
			mode_next = fw_vec_call ? SAM_FW : SAM_SYS;
		end else if (irq_go) begin
			mode_next = irq_tgt;
		end else if (ret_ok) begin
			mode_next = stack_reg[2'(sp_reg - 2'h1)];
		end else if (user_call || mc_drop) begin
			mode_next = SAM_USER;
		end else if (mode_reg == SAM_BOOT && enter_test) begin
			mode_next = SAM_TEST;
		end else if (mode_reg == SAM_BOOT && boot_done) begin
			mode_next = SAM_FW;
		end
		// boot is never a target again
		if (mode_next == SAM_BOOT && mode_reg != SAM_BOOT) begin
			mode_next = mode_reg;
		end
	end

	// ------------------------------------------------------------
	// sequential state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= SAM_BOOT;
			sp_reg <= 2'h0;
			irq_active_reg <= 1'b0;
			exc_busy_reg <= 3'h0;
		end else begin
			mode_reg <= mode_next;
			if (push && sp_reg != 2'(SAM_DEPTH - 1)) begin
				sp_reg <= 2'(sp_reg + 2'h1);
			end else if (ret_ok && !push) begin
				sp_reg <= 2'(sp_reg - 2'h1);
			end
			if (irq_go) begin
				irq_active_reg <= 1'b1;
			end else if (ret_ok) begin
				irq_active_reg <= 1'b0;
			end
			if (exc_any) begin
				exc_busy_reg[bank_of(mode_reg)] <= 1'b1;
			end else if (ret_ok) begin
				exc_busy_reg <= 3'h0;
			end
		end
	end

	// return stack, flip-flops by index; fixed user entry pushes nothing
	always_ff @(posedge clk) begin
		if (push) begin
			stack_reg[sp_reg] <= mode_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_cfg_reg <= SAM_IRQ_RST;
		end else if (reg_wr && in_icfg && m_sys) begin
			irq_cfg_reg <= reg_wdata[1:0];
		end
	end

	genvar gb;
	generate
		for (gb = 0; gb < 3; gb++) begin : g_bank
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					bank_reg[gb] <= '{default: SAM_ZERO8};
				end else if (reg_wr && in_bank && bk == 2'(gb)) begin
					bank_reg[gb][bidx] <= reg_wdata;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	wire logic [7:0] rd_mux = (!reg_rd || acc_viol) ? SAM_ZERO8 :
		in_bank ? bank_reg[bk][bidx] :
		in_mc ? {6'h00, m_sup, m_sys} :
		in_icfg ? {6'h00, irq_cfg_reg} : SAM_ZERO8; // keys never read back

	wire logic [SAM_GROUPS-1:0] key_stb_next = (reg_wr && in_key && key_ok) ?
		16'(1 << reg_addr[2:0]) : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= SAM_ZERO8;
		end else begin
			rdata_reg <= rd_mux;
		end
	end

	// exception request and the mode it was raised in travel together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exc_reg <= 1'b0;
			exc_mode_reg <= 3'h0;
		end else begin
			exc_reg <= viol;
			exc_mode_reg <= mode_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			push_reg <= 1'b0;
		end else begin
			push_reg <= push;
		end
	end

	// nested exception is unrecoverable, so the core is told to reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_reg <= 1'b0;
		end else begin
			rst_reg <= nested;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			key_stb_reg <= '0;
		end else begin
			key_stb_reg <= key_stb_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign cur_mode = mode_reg;
	assign exc_req = exc_reg;
	assign exc_mode = exc_mode_reg;
	assign push_ret = push_reg;
	assign force_reset = rst_reg;
	assign irq_mode = irq_cfg_reg;
	assign key_wr_stb = key_stb_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_key_noread: assert property (reg_rd && in_key |=> reg_rdata == SAM_ZERO8)
		else $error("key register read returned data");
	chk_rng_user: assert property (reg_rd && in_rng && m_user |=> exc_req)
		else $error("user rng read not trapped");
	chk_unmapped_exc: assert property (acc && !mapped |=> exc_req && exc_mode == $past(cur_mode))
		else $error("unmapped access not trapped");
	chk_group_block: assert property (acc && in_group && m_user && !grant_user[grp] |=> exc_req)
		else $error("ungranted group access passed");
	chk_sysvec_bad: assert property (sys_vec_call && m_sys |=> exc_req && cur_mode == SAM_SYS)
		else $error("system vector from system mode accepted");
	chk_user_entry: assert property (user_call && !exc_any && !vec_go && !irq_go && !ret_ok
		|=> cur_mode == SAM_USER && !push_ret)
		else $error("fixed entry did not enter user mode");
	chk_clear_only: assert property (mc_wr && m_user |=> cur_mode == SAM_USER)
		else $error("user raised its own mode");
	chk_no_boot: assert property (cur_mode != SAM_BOOT |=> cur_mode != SAM_BOOT)
		else $error("boot mode re-entered");
	chk_exc_pulse: assert property (exc_req && !$past(viol, 1) |-> 1'b0)
		else $error("exception without cause");
	chk_nested_rst: assert property (nested |=> force_reset)
		else $error("nested exception did not reset");

	chk_key_onehot: assert property (reg_wr && in_key && key_ok |=> $onehot(key_wr_stb))
		else $error("key write strobe not one-hot");
	chk_key_user_wr: assert property (reg_wr && in_key && m_user |=> exc_req && key_wr_stb == '0)
		else $error("user key write not trapped");
	chk_key_no_stb: assert property (!(reg_wr && in_key) |=> key_wr_stb == '0)
		else $error("key strobe without key write");
	chk_rng_sys: assert property (reg_rd && in_rng && m_sys && !sys_vec_call && !ret_exec
		|=> !exc_req)
		else $error("system rng read trapped");
	chk_rng_write: assert property (reg_wr && in_rng |=> exc_req)
		else $error("rng write not trapped");
	chk_viol_rdata: assert property (reg_rd && acc_viol |=> reg_rdata == SAM_ZERO8)
		else $error("refused read returned data");
	chk_no_viol: assert property (!viol |=> !exc_req)
		else $error("exception without violation");
	chk_idle_rdata: assert property (!reg_rd |=> reg_rdata == SAM_ZERO8)
		else $error("read data without read");
	chk_mgmt_sys: assert property (acc && in_mgmt && m_sys && !sys_vec_call && !ret_exec
		|=> !exc_req)
		else $error("system management access trapped");
	chk_mgmt_user: assert property (acc && in_mgmt && m_user |=> exc_req)
		else $error("user management access passed");
	chk_group_fw: assert property (acc && in_group && mode_reg == SAM_FW && !grant_fw[grp]
		|=> exc_req)
		else $error("ungranted firmware group access passed");
	chk_group_grant: assert property (acc && in_group && m_user && grant_user[grp] &&
		!sys_vec_call && !ret_exec |=> !exc_req)
		else $error("granted user group access trapped");
	chk_bank_write: assert property (reg_wr && in_bank
		|=> bank_reg[$past(bk)][$past(bidx)] == $past(reg_wdata))
		else $error("banked write missed its copy");
	chk_icfg_user: assert property (reg_wr && in_icfg && m_user |=> exc_req && $stable(irq_mode))
		else $error("user changed interrupt mode");
	chk_icfg_sys: assert property (reg_wr && in_icfg && m_sys |=> irq_mode == $past(reg_wdata[1:0]))
		else $error("system interrupt mode write lost");
	chk_irq_sys: assert property (irq_go && !vec_go && irq_cfg_reg == 2'h1 |=> cur_mode == SAM_SYS)
		else $error("interrupt not taken in system mode");
	chk_fw_vec: assert property (fw_vec_call && !exc_any |=> cur_mode == SAM_FW)
		else $error("firmware vector missed firmware mode");
	chk_sys_vec: assert property (sys_vec_call && m_user && !exc_any && !fw_vec_call
		|=> cur_mode == SAM_SYS)
		else $error("system vector missed system mode");
	chk_vec_push: assert property (vec_go |=> push_ret)
		else $error("vector call pushed nothing");
	chk_entry_nopush: assert property (user_call && !push |=> !push_ret)
		else $error("fixed entry pushed a return");
	chk_push_cause: assert property (push_ret |-> $past(push))
		else $error("push without cause");
	chk_ret_restore: assert property (ret_ok && !exc_any && !vec_go && !irq_go
		|=> cur_mode == $past(stack_reg[2'(sp_reg - 2'h1)]))
		else $error("return did not restore mode");
	chk_ret_cfg: assert property (ret_exec && m_user && irq_cfg_reg != 2'h0 |=> exc_req)
		else $error("user return with system interrupts");
	chk_ret_noirq: assert property (ret_exec && m_user && !irq_active_reg |=> exc_req)
		else $error("user return without interrupt");
	chk_mc_set: assert property (mc_wr && m_sys && reg_wdata[SAM_MC_SYS] && !exc_any && !vec_go
		&& !irq_go && !ret_ok |=> cur_mode == SAM_SYS)
		else $error("mode write with set bit changed mode");
	chk_mc_fw: assert property (mc_wr && mode_reg == SAM_FW && !exc_any && !vec_go && !irq_go
		&& !ret_ok |=> cur_mode == SAM_FW)
		else $error("mode write left firmware mode");
	chk_boot_fw: assert property (mode_reg == SAM_BOOT && boot_done && !enter_test && !exc_any
		&& !vec_go && !irq_go && !ret_ok |=> cur_mode == SAM_FW)
		else $error("boot did not leave to firmware");
	chk_boot_test: assert property (mode_reg == SAM_BOOT && enter_test && !exc_any && !vec_go
		&& !irq_go && !ret_ok |=> cur_mode == SAM_TEST)
		else $error("boot did not leave to test");
	chk_busy_set: assert property (exc_any |=> exc_busy_reg[bank_of($past(mode_reg))])
		else $error("exception did not mark its mode");
	chk_first_exc: assert property (exc_any && !exc_busy_reg[bank_of(mode_reg)] |=> !force_reset)
		else $error("first exception forced reset");
	chk_exc_stay: assert property (exc_any |=> cur_mode == $past(cur_mode))
		else $error("exception changed mode");
	chk_rst_cause: assert property (force_reset |-> $past(nested))
		else $error("reset without nested exception");
	chk_exc_tag: assert property (viol |=> exc_req && exc_mode == $past(cur_mode))
		else $error("exception mode tag wrong");

	cov_user_call: cover property (user_call);
	cov_irq_ret: cover property (irq_go ##[1:20] ret_ok);
	cov_nested: cover property (nested);
	cov_fw_vec: cover property (fw_vec_call ##1 cur_mode == SAM_FW);
endmodule
`default_nettype wire

// >>> verilog/sam_pkg.sv
// constants, types and the operation list for the register access and mode control block
// Operation
// - key registers write-only, mode-gated writes
// - random output read-only, mode-gated reads
// - violation or unmapped address raises exception
// - banked registers: user, system, super copies
// - groups blocked until system grants access
// - non-group rights fixed in logic
// - system vector enters system, firmware vector firmware
// - system vector only from user mode
// - exception marks mode; nested exception resets
// - interrupt mode selectable by system code
// - return restores mode before event
// - user return needs user irq and active
// - system call to 0x800000 enters user
// - fixed user entry pushes no return address
// - direct mode writes only clear bits
// - system mode reaches every register
// - user grantable group access like system
// - software cannot reach boot or test; firmware only via vector, interrupt or return
// - group rights come from translation unit
// - boot may leave, never re-entered
package sam_pkg;
	typedef enum logic [2:0] {
		SAM_BOOT,
		SAM_TEST,
		SAM_FW,
		SAM_SYS,
		SAM_USER
	} sam_mode_t;

	localparam int SAM_GROUPS = 16;
	localparam int SAM_DEPTH = 4;
	localparam int SAM_AW = 8;

	// register map, byte offsets on the core's register port
	localparam logic [7:0] SAM_GROUP_BASE = 8'h80;
	localparam logic [7:0] SAM_GROUP_LAST = 8'hBF;
	localparam int SAM_GROUP_SHIFT = 2;
	localparam logic [7:0] SAM_KEY_LO = 8'h10;
	localparam logic [7:0] SAM_KEY_HI = 8'h17;
	localparam logic [7:0] SAM_RNG_OUT = 8'h18;
	localparam logic [7:0] SAM_BANK_LO = 8'h20;
	localparam logic [7:0] SAM_BANK_HI = 8'h23;
	localparam logic [7:0] SAM_MODE_CTRL = 8'h30;
	localparam logic [7:0] SAM_IRQ_CFG = 8'h31;
	localparam logic [7:0] SAM_MGMT_LO = 8'h40;
	localparam logic [7:0] SAM_MGMT_HI = 8'h4F;

	// mode control bits: bit0 system, bit1 super
	localparam int SAM_MC_SYS = 0;
	localparam int SAM_MC_SUP = 1;
	localparam logic [1:0] SAM_IRQ_RST = 2'h0;
	localparam logic [7:0] SAM_ZERO8 = 8'h00;
	localparam logic [23:0] SAM_USER_ENTRY = 24'h800000;
endpackage
